// ==== acl_action_rewrite_decode.sv ====
// Access-list action decode with AHB-Lite registers
//
// Behaviour
// [R01] Command bits 1:0 select PTP action
// [R02] Command bits 3:2 select added delay
// [R03] Sequence value 1 inserts and increments counter
// [R04] Values 2,3 enable delay request handling
// [R05] Bit 5 set clears forwarded bits 5:4
// [R06] Bit 6 copies SMAC; bit 7 port SMAC
// [R07] Command travels to rewriter in header field
// [R08] Hop flag decrements TTL or hop limit
// [R09] Swap sub-modes 4-7 preset TTL instead
// [R10] Test-sequence flag restricts route/swap mode
// [R11] Mode 0x8 replaces configured top DMAC bits if test-only flag set, else whole DMAC
// [R12] L4 flag sets ports from tag, mask
// [R13] CPU copy reports logical tag in header
// [R14] Twelve-bit hit counter index passed on
// [R15] Swap flag swaps MACs or encodes interval
// [R16] Interval: flag clear 0..7, set -8..-1
// [R17] Mode bit 3 selects swapping sub-modes
// [R18] Checksums follow modified TTL and ports
`timescale 1ns/1ps
module acl_action_rewrite_decode #(
    parameter int SEL_W = 2,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic act_valid_i,
    output logic act_ready_o,
    input wire logic [7:0] frame_rewrite_command_i,
    input wire logic hop_count_update_flag_i,
    input wire logic test_sequence_only_flag_i,
    input wire logic test_sequence_class_i,
    input wire logic l4_port_replace_flag_i,
    input wire logic [15:0] entry_logical_tag_i,
    input wire logic [15:0] entry_tag_mask_i,
    input wire logic [11:0] hit_counter_index_i,
    input wire logic mac_swap_flag_i,
    input wire logic [2:0] log_interval_field_i,
    input wire logic [3:0] route_swap_mode_i,
    input wire logic [47:0] replacement_mac_value_i,
    input wire logic processor_copy_flag_i,
    input wire logic [SEL_W-1:0] sequence_selector_field_i,
    input wire logic mcast_delay_resp_i,
    input wire logic is_ipv4_i,
    input wire logic [47:0] dmac_i,
    input wire logic [47:0] smac_i,
    input wire logic [7:0] ttl_i,
    input wire logic [7:0] proto_i,
    input wire logic [15:0] ip_csum_i,
    input wire logic [15:0] sport_i,
    input wire logic [15:0] dport_i,
    input wire logic [15:0] l4_csum_i,
    output logic rw_valid_o,
    input wire logic rw_ready_i,
    output logic [7:0] rw_command_o,
    output logic [1:0] rw_ptp_op_o,
    output logic [31:0] rw_delay_o,
    output logic rw_seq_insert_o,
    output logic [15:0] rw_seq_num_o,
    output logic rw_delay_req_o,
    output logic rw_receipt_ts_o,
    output logic [47:0] rw_dmac_o,
    output logic [47:0] rw_smac_o,
    output logic [7:0] rw_ttl_o,
    output logic [15:0] rw_ip_csum_o,
    output logic [15:0] rw_sport_o,
    output logic [15:0] rw_dport_o,
    output logic [15:0] rw_l4_csum_o,
    output logic rw_classify_valid_o,
    output logic [15:0] rw_classify_result_o,
    output logic [11:0] rw_hit_counter_index_o,
    output logic rw_log_valid_o,
    output logic [3:0] rw_log_interval_o
);
    localparam int NSEQ = 1 << SEL_W;
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

    typedef struct packed {
        acl_rw_pkg::stg_e stg;
        logic rdy;
        acl_rw_pkg::res_s res;
        logic [31:0] ctrl;
        logic [31:0] edly;
        logic [31:0] idly1;
        logic [31:0] idly2;
        logic [31:0] swap;
        logic [47:0] pmac;
        logic [15:0] frames;
        logic [NSEQ-1:0][15:0] seq;
        logic dph_wr;
        logic [acl_rw_pkg::ADDR_W-1:0] dph_addr;
        logic [31:0] rdata;
        logic hrdy;
        logic resp;
    } st_s;

    st_s q;
    st_s d;
    logic acc;
    logic push;
    logic fifo_in_ready;
    logic [LVL_W-1:0] fifo_level;
    acl_rw_pkg::res_s fifo_out;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // One's complement checksum update
    function automatic logic [15:0] csum_upd(input logic [15:0] hc,
        input logic [15:0] old_w, input logic [15:0] new_w);
        logic [17:0] s;
        s = {2'h0, ~hc} + {2'h0, ~old_w} + {2'h0, new_w};
        s = {2'h0, s[15:0]} + {16'h0, s[17:16]};
        s = {2'h0, s[15:0]} + {16'h0, s[17:16]};
        return ~s[15:0];
    endfunction

    // Top w bits set
    function automatic logic [47:0] top_mask(input logic [5:0] w);
        logic [47:0] m;
        m = ~({acl_rw_pkg::MAC_W{1'b1}} >> w);
        if (w > 6'(acl_rw_pkg::MAC_W))
        begin
            m = {acl_rw_pkg::MAC_W{1'b1}};
        end
        return m;
    endfunction

    function automatic logic [31:0] rd_reg(input st_s s,
        input logic [acl_rw_pkg::ADDR_W-1:0] a, input logic [LVL_W-1:0] lv);
        logic [31:0] v;
        v = '0;
        case (a)
            acl_rw_pkg::OFS_CTRL: v = s.ctrl;
            acl_rw_pkg::OFS_EDLY: v = s.edly;
            acl_rw_pkg::OFS_IDLY1: v = s.idly1;
            acl_rw_pkg::OFS_IDLY2: v = s.idly2;
            acl_rw_pkg::OFS_SWAP: v = s.swap;
            acl_rw_pkg::OFS_SMAC_LO: v = s.pmac[31:0];
            acl_rw_pkg::OFS_SMAC_HI: v = {16'h0, s.pmac[47:32]};
            acl_rw_pkg::OFS_STAT: v = {8'h0, 8'(lv), s.frames};
            default: v = '0;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        acl_rw_pkg::res_s r;
        logic [7:0] cmd;
        logic [3:0] mode;
        logic route_on;
        logic bus_sel;
        logic [47:0] dm;
        logic [47:0] sm;
        logic [47:0] wm;
        logic [7:0] ttl_n;
        acl_rw_pkg::seq_cmd_e seqc;
        r = '0;
        cmd = frame_rewrite_command_i;
        mode = route_swap_mode_i;
        route_on = 1'b0;
        bus_sel = 1'b0;
        dm = dmac_i;
        sm = smac_i;
        wm = '0;
        ttl_n = ttl_i;
        seqc = acl_rw_pkg::seq_cmd_e'(
            cmd[acl_rw_pkg::CMD_SEQ_MSB:acl_rw_pkg::CMD_SEQ_LSB]);
        d = q;
        d.hrdy = 1'b1;
        d.resp = 1'b0;
        acc = act_valid_i && q.rdy;
        push = (q.stg == acl_rw_pkg::STG_FULL) && fifo_in_ready;

        // Writes land in data phase
        if (q.dph_wr)
        begin
            case (q.dph_addr)
                acl_rw_pkg::OFS_CTRL: d.ctrl = hwdata_i;
                acl_rw_pkg::OFS_EDLY: d.edly = hwdata_i;
                acl_rw_pkg::OFS_IDLY1: d.idly1 = hwdata_i;
                acl_rw_pkg::OFS_IDLY2: d.idly2 = hwdata_i;
                acl_rw_pkg::OFS_SWAP: d.swap = hwdata_i;
                acl_rw_pkg::OFS_SMAC_LO: d.pmac[31:0] = hwdata_i;
                acl_rw_pkg::OFS_SMAC_HI:
                    d.pmac[47:32] = hwdata_i[acl_rw_pkg::SMAC_HI_MSB:0];
                default: ;
            endcase
        end
        bus_sel = hsel_i && htrans_i[1] && hready_i;
        d.dph_wr = bus_sel && hwrite_i;
        d.dph_addr = haddr_i[acl_rw_pkg::ADDR_W-1:0];
        d.rdata = (bus_sel && !hwrite_i) ?
            rd_reg(d, haddr_i[acl_rw_pkg::ADDR_W-1:0], fifo_level) : '0;

        // [R07] Command forwarded in header
        r.cmd = cmd;
        // [R05] Clear sequence bits
        if (cmd[acl_rw_pkg::CMD_SEQ_MSB])
        begin
            r.cmd[acl_rw_pkg::CMD_SEQ_MSB:acl_rw_pkg::CMD_SEQ_LSB] = 2'h0;
        end
        // [R01] PTP action decode
        r.ptp = acl_rw_pkg::ptp_op_e'(
            cmd[acl_rw_pkg::CMD_PTP_MSB:acl_rw_pkg::CMD_PTP_LSB]);
        // [R02] Delay selection
        case (acl_rw_pkg::dly_sel_e'(
            cmd[acl_rw_pkg::CMD_DLY_MSB:acl_rw_pkg::CMD_DLY_LSB]))
            acl_rw_pkg::DLY_EGRESS: r.delay = q.edly;
            acl_rw_pkg::DLY_INGR1: r.delay = q.idly1;
            acl_rw_pkg::DLY_INGR2: r.delay = q.idly2;
            default: r.delay = '0;
        endcase
        // [R03] Sequence number fill
        r.seq_ins = (seqc == acl_rw_pkg::SEQ_FILL);
        r.seq_num = r.seq_ins ? q.seq[sequence_selector_field_i] : '0;
        // [R04] Delay request handling
        r.dreq = (seqc == acl_rw_pkg::SEQ_DREQ_RCPT) ||
            (seqc == acl_rw_pkg::SEQ_DREQ_KEEP);
        r.rcpt_ts = (seqc == acl_rw_pkg::SEQ_DREQ_RCPT);
        // [R16] Interval encoding
        r.log_valid = cmd[acl_rw_pkg::CMD_SEQ_MSB] && mcast_delay_resp_i;
        r.log_int = r.log_valid ? {mac_swap_flag_i, log_interval_field_i}
            : '0;

        // [R15] Swap unless overloaded
        if (mac_swap_flag_i && !cmd[acl_rw_pkg::CMD_SEQ_MSB])
        begin
            dm = smac_i;
            sm = dmac_i;
        end
        // [R06] MAC overwrite bits
        if (cmd[acl_rw_pkg::CMD_DMAC])
        begin
            dm = smac_i;
        end
        if (cmd[acl_rw_pkg::CMD_SMAC])
        begin
            sm = q.pmac;
        end
        // [R10] Test-sequence gating
        route_on = (mode != acl_rw_pkg::MODE_NONE) &&
            ((mode == acl_rw_pkg::MODE_REPL_DMAC) ||
            !test_sequence_only_flag_i || test_sequence_class_i);
        // [R11] DMAC replace, partial if test-only
        if (route_on && mode == acl_rw_pkg::MODE_REPL_DMAC)
        begin
            wm = test_sequence_only_flag_i ? top_mask(
                q.swap[acl_rw_pkg::SWAP_WID_MSB:acl_rw_pkg::SWAP_WID_LSB])
                : {acl_rw_pkg::MAC_W{1'b1}};
            dm = (dm & ~wm) | (replacement_mac_value_i & wm);
        end
        // [R17] Swapping sub-mode replace
        if (route_on && mode == acl_rw_pkg::MODE_REPL_SMAC)
        begin
            sm = replacement_mac_value_i;
        end
        r.dmac = dm;
        r.smac = sm;

        // [R08] Hop count update
        if (hop_count_update_flag_i)
        begin
            // [R09] Preset in swap sub-modes 4-7
            if (route_on && mode[acl_rw_pkg::MODE_SWAP] &&
                mode[acl_rw_pkg::MODE_SUB_HI])
            begin
                ttl_n = q.swap[acl_rw_pkg::SWAP_TTL_MSB:
                    acl_rw_pkg::SWAP_TTL_LSB];
            end
            else if (ttl_i != 8'h0)
            begin
                ttl_n = ttl_i - 8'h1;
            end
        end
        r.ttl = ttl_n;
        // [R18] Header checksum fix-up
        r.ip_csum = is_ipv4_i ?
            csum_upd(ip_csum_i, {ttl_i, proto_i}, {ttl_n, proto_i})
            : ip_csum_i;
        // [R12] L4 port replace
        r.dport = l4_port_replace_flag_i ? entry_logical_tag_i : dport_i;
        r.sport = l4_port_replace_flag_i ? entry_tag_mask_i : sport_i;
        // [R18] L4 checksum fix-up
        r.l4_csum = csum_upd(csum_upd(l4_csum_i, sport_i, r.sport),
            dport_i, r.dport);
        // [R13] Tag to CPU result
        r.cl_valid = processor_copy_flag_i;
        r.classify_result_field = processor_copy_flag_i ? entry_logical_tag_i : '0;
        // [R14] Counter index
        r.cnt_idx = hit_counter_index_i;

        if (push)
        begin
            d.stg = acl_rw_pkg::STG_EMPTY;
            d.frames = q.frames + 16'h1;
        end
        if (acc)
        begin
            d.stg = acl_rw_pkg::STG_FULL;
            d.res = r;
            // [R03] Counter increment
            if (r.seq_ins)
            begin
                d.seq[sequence_selector_field_i] =
                    q.seq[sequence_selector_field_i] + 16'h1;
            end
        end
        d.rdy = d.ctrl[acl_rw_pkg::CTRL_EN] &&
            (d.stg == acl_rw_pkg::STG_EMPTY);
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            q <= '0;
            q.ctrl <= acl_rw_pkg::CTRL_RST;
            q.hrdy <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result FIFO and outputs

    rw_fifo #(
        .W($bits(acl_rw_pkg::res_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(q.stg == acl_rw_pkg::STG_FULL),
        .in_ready_o(fifo_in_ready),
        .in_data_i(q.res),
        .out_valid_o(rw_valid_o),
        .out_ready_i(rw_ready_i),
        .out_data_o(fifo_out),
        .level_o(fifo_level)
    );

    assign hrdata_o = q.rdata;
    assign hreadyout_o = q.hrdy;
    assign hresp_o = q.resp;
    assign act_ready_o = q.rdy;
    assign rw_command_o = fifo_out.cmd;
    assign rw_ptp_op_o = fifo_out.ptp;
    assign rw_delay_o = fifo_out.delay;
    assign rw_seq_insert_o = fifo_out.seq_ins;
    assign rw_seq_num_o = fifo_out.seq_num;
    assign rw_delay_req_o = fifo_out.dreq;
    assign rw_receipt_ts_o = fifo_out.rcpt_ts;
    assign rw_dmac_o = fifo_out.dmac;
    assign rw_smac_o = fifo_out.smac;
    assign rw_ttl_o = fifo_out.ttl;
    assign rw_ip_csum_o = fifo_out.ip_csum;
    assign rw_sport_o = fifo_out.sport;
    assign rw_dport_o = fifo_out.dport;
    assign rw_l4_csum_o = fifo_out.l4_csum;
    assign rw_classify_valid_o = fifo_out.cl_valid;
    assign rw_classify_result_o = fifo_out.classify_result_field;
    assign rw_hit_counter_index_o = fifo_out.cnt_idx;
    assign rw_log_valid_o = fifo_out.log_valid;
    assign rw_log_interval_o = fifo_out.log_int;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_PTP_OP: assert property ( // [R01]
        acc |=> q.res.ptp == $past(frame_rewrite_command_i[1:0]))
        else $error("PTP op");
    AST_DELAY_EGR: assert property ( // [R02]
        acc && frame_rewrite_command_i[3:2] == 2'h1
        |=> q.res.delay == $past(q.edly))
        else $error("Egress delay");
    AST_SEQ_INC: assert property ( // [R03]
        acc && frame_rewrite_command_i[5:4] == 2'h1
        |=> q.seq[$past(sequence_selector_field_i)] ==
        $past(q.seq[sequence_selector_field_i]) + 16'h1)
        else $error("Seq increment");
    AST_RCPT: assert property ( // [R04]
        acc |=> q.res.rcpt_ts == ($past(frame_rewrite_command_i[5:4])
        == 2'h2))
        else $error("Receipt flag");
    AST_CMD_CLR: assert property ( // [R05]
        acc && frame_rewrite_command_i[5]
        |=> q.res.cmd[5:4] == 2'h0 &&
        q.res.cmd[7:6] == $past(frame_rewrite_command_i[7:6]))
        else $error("Cmd clear");
    AST_TTL_DEC: assert property ( // [R08]
        acc && hop_count_update_flag_i && !route_swap_mode_i[3] &&
        ttl_i != 8'h0 |=> q.res.ttl == $past(ttl_i) - 8'h1)
        else $error("TTL decrement");
    AST_TTL_PRE: assert property ( // [R09]
        acc && hop_count_update_flag_i && route_swap_mode_i == 4'hc &&
        !test_sequence_only_flag_i |=> q.res.ttl == $past(q.swap[7:0]))
        else $error("TTL preset");
    AST_PORTS: assert property ( // [R12]
        acc && l4_port_replace_flag_i
        |=> q.res.dport == $past(entry_logical_tag_i) &&
        q.res.sport == $past(entry_tag_mask_i))
        else $error("L4 ports");
    AST_LOG: assert property ( // [R16]
        acc && frame_rewrite_command_i[5] && mcast_delay_resp_i
        |=> q.res.log_valid && q.res.log_int ==
        {$past(mac_swap_flag_i), $past(log_interval_field_i)})
        else $error("Log interval");
    AST_HOLD: assert property ( // [R07]
        q.stg == acl_rw_pkg::STG_FULL && !fifo_in_ready
        |=> q.stg == acl_rw_pkg::STG_FULL && $stable(q.res) && !q.rdy)
        else $error("Stage hold");
endmodule

// ==== acl_action_rewrite_decode_tb.sv ====
// Self-checking bench of the action decode and rewrite block
`timescale 1ns/1ps
module acl_action_rewrite_decode_tb;
    typedef struct packed {
        logic [47:0] dm, sm;
        logic [31:0] dly;
        logic [15:0] sn, sp, dp, cr;
        logic [11:0] hc;
        logic [7:0] cmd, ttl;
        logic [3:0] li;
        logic [1:0] ptp;
        logic si, dr, rt, cv, lv;
    } obs_s;
    logic sys_clk_i, resetn_i, hsel_i, hwrite_i, act_valid_i, rw_ready_i;
    logic hreadyout_o, hresp_o, act_ready_o, rw_valid_o, is_ipv4_i;
    logic hop_count_update_flag_i, test_sequence_only_flag_i;
    logic test_sequence_class_i, l4_port_replace_flag_i, mac_swap_flag_i;
    logic processor_copy_flag_i, mcast_delay_resp_i, rw_seq_insert_o;
    logic rw_delay_req_o, rw_receipt_ts_o, rw_classify_valid_o;
    logic rw_log_valid_o, stall, slow;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rw_delay_o, cnt, seen;
    logic [1:0] htrans_i, sequence_selector_field_i, rw_ptp_op_o;
    logic [2:0] hsize_i, log_interval_field_i;
    logic [7:0] frame_rewrite_command_i, ttl_i, proto_i, rw_command_o;
    logic [7:0] rw_ttl_o;
    logic [15:0] entry_logical_tag_i, entry_tag_mask_i, ip_csum_i, sport_i;
    logic [15:0] dport_i, l4_csum_i, rw_ip_csum_o, rw_sport_o, rw_dport_o;
    logic [15:0] rw_l4_csum_o, rw_seq_num_o, rw_classify_result_o;
    logic [11:0] hit_counter_index_i, rw_hit_counter_index_o;
    logic [3:0] route_swap_mode_i, rw_log_interval_o;
    logic [47:0] replacement_mac_value_i, dmac_i, smac_i, rw_dmac_o;
    logic [47:0] rw_smac_o;
    wire logic hready_i;
    obs_s word, got, last;
    int fail_count, num_checks, n, acc;
    logic [31:0] dl [4] = '{32'h0, 32'h100, 32'h200, 32'h300};
    assign hready_i = hreadyout_o;
    assign word = {rw_dmac_o, rw_smac_o, rw_delay_o, rw_seq_num_o,
        rw_sport_o, rw_dport_o, rw_classify_result_o, rw_hit_counter_index_o,
        rw_command_o, rw_ttl_o, rw_log_interval_o, rw_ptp_op_o,
        rw_seq_insert_o, rw_delay_req_o, rw_receipt_ts_o,
        rw_classify_valid_o, rw_log_valid_o};
    acl_action_rewrite_decode DUT (.*);
    rw_sink #(.W($bits(obs_s))) sink (.sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i), .stall_i(stall), .slow_i(slow),
        .valid_i(rw_valid_o), .ready_o(rw_ready_i), .word_i(word),
        .last_o(last), .count_o(cnt));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %0t exp %h got %h", $time, e, g);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= {24'h0, a};
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1 && k++ < 50);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1 && k++ < 99);
        if (!w)
            chk(d, hrdata_o);
    endtask
    // n ends at 41 if refused
    task act();
        @(posedge sys_clk_i);
        act_valid_i <= 1'b1;
        n = 0;
        do @(posedge sys_clk_i); while (act_ready_o !== 1'b1 && n++ < 40);
        act_valid_i <= 1'b0;
    endtask
    task rx();
        int k;
        k = 0;
        while (seen == cnt && k++ < 200) @(posedge sys_clk_i);
        seen = cnt;
        got = last;
    endtask
    task seqt(input logic [1:0] v, sel, input logic sw,
        input logic [2:0] lf, input logic [15:0] sn, input logic [3:0] li);
        frame_rewrite_command_i <= {2'b0, v, 4'h0};
        sequence_selector_field_i <= sel;
        mac_swap_flag_i <= sw;
        log_interval_field_i <= lf;
        mcast_delay_resp_i <= 1'b1;
        act();
        rx();
        chk(v[1] ? 8'h00 : {2'b0, v, 4'h0}, got.cmd);
        chk(v == 2'h1, got.si);
        chk(v == 2'h1 ? sn : 16'h0, got.sn);
        chk(v[1], got.dr);
        chk(v == 2'h2, got.rt);
        chk(v[1], got.lv);
        chk(v[1] ? li : 4'h0, got.li);
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    initial
    begin
        #1000000;
        fail_count++;
        end_sim();
    end
    initial
    begin
        {resetn_i, hsel_i, hwrite_i, act_valid_i, is_ipv4_i, stall, slow,
            hop_count_update_flag_i, test_sequence_only_flag_i,
            test_sequence_class_i, l4_port_replace_flag_i, mac_swap_flag_i,
            processor_copy_flag_i, mcast_delay_resp_i, haddr_i, hwdata_i,
            htrans_i, sequence_selector_field_i, log_interval_field_i,
            frame_rewrite_command_i, ttl_i, proto_i, entry_logical_tag_i,
            entry_tag_mask_i, ip_csum_i, sport_i, dport_i, l4_csum_i,
            hit_counter_index_i, route_swap_mode_i, replacement_mac_value_i,
            dmac_i, smac_i, seen} = '0;
        hsize_i = 3'h2;
        repeat (8) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        ahb(1'b0, 8'h00, acl_rw_pkg::CTRL_RST);
        ahb(1'b1, 8'h20, 32'h5a5a_5a5a);
        ahb(1'b0, 8'h20, 32'h0);
        ahb(1'b1, 8'h04, dl[1]);
        ahb(1'b1, 8'h08, dl[2]);
        ahb(1'b1, 8'h0c, dl[3]);
        ahb(1'b0, 8'h0c, dl[3]);
        ahb(1'b1, 8'h10, 32'h0000_0822);
        ahb(1'b1, 8'h14, 32'h3344_5566);
        ahb(1'b1, 8'h18, 32'h0000_1122);
        ahb(1'b1, 8'h00, 32'h0);
        act();
        chk(41, n);
        ahb(1'b1, 8'h00, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            frame_rewrite_command_i <= {4'h0, i[1:0], i[1:0]};
            act();
            rx();
            chk({i[1:0], i[1:0]}, got.cmd);
            chk(i, got.ptp);
            chk(dl[i], got.dly);
        end
        seqt(2'h1, 2'h2, 1'b0, 3'h0, 16'h0, 4'h0);
        seqt(2'h1, 2'h2, 1'b0, 3'h0, 16'h1, 4'h0);
        seqt(2'h1, 2'h1, 1'b0, 3'h0, 16'h0, 4'h0);
        seqt(2'h2, 2'h0, 1'b1, 3'h3, 16'h0, 4'hb);
        seqt(2'h3, 2'h0, 1'b0, 3'h7, 16'h0, 4'h7);
        seqt(2'h3, 2'h0, 1'b1, 3'h7, 16'h0, 4'hf);
        frame_rewrite_command_i <= 8'hc0;
        mac_swap_flag_i <= 1'b0;
        mcast_delay_resp_i <= 1'b0;
        hop_count_update_flag_i <= 1'b1;
        ttl_i <= 8'h40;
        l4_port_replace_flag_i <= 1'b1;
        entry_logical_tag_i <= 16'hbeef;
        entry_tag_mask_i <= 16'h1234;
        processor_copy_flag_i <= 1'b1;
        hit_counter_index_i <= 12'hfff;
        dmac_i <= 48'h111111111111;
        smac_i <= 48'h020304050607;
        act();
        rx();
        chk(48'h020304050607, got.dm);
        chk(48'h112233445566, got.sm);
        chk(8'h3f, got.ttl);
        chk(32'hbeef_1234, {got.dp, got.sp});
        chk(17'h1_beef, {got.cv, got.cr});
        chk(12'hfff, got.hc);
        frame_rewrite_command_i <= 8'h00;
        route_swap_mode_i <= 4'hc;
        act();
        rx();
        chk(8'h22, got.ttl);
        test_sequence_only_flag_i <= 1'b1;
        act();
        rx();
        chk(8'h3f, got.ttl);
        route_swap_mode_i <= 4'h8;
        replacement_mac_value_i <= 48'haaaaaaaaaaaa;
        act();
        rx();
        chk(48'haa1111111111, got.dm);
        stall <= 1'b1;
        acc = 0;
        for (int k = 0; k < 34; k++)
        begin
            hit_counter_index_i <= k[11:0];
            act();
            acc += (n < 41);
        end
        chk(33, acc);
        stall <= 1'b0;
        slow <= 1'b1;
        for (int k = 0; k < 32; k++)
        begin
            rx();
            chk(k, got.hc);
        end
        end_sim();
    end
endmodule

// ==== acl_rw_pkg.sv ====
// Constants and types of the action decode block
package acl_rw_pkg;

    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_EDLY = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IDLY1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IDLY2 = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_SWAP = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SMAC_LO = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_SMAC_HI = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h1c;

    localparam int CTRL_EN = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int SWAP_TTL_LSB = 0;
    localparam int SWAP_TTL_MSB = 7;
    localparam int SWAP_WID_LSB = 8;
    localparam int SWAP_WID_MSB = 13;
    localparam int SMAC_HI_MSB = 15;

    localparam int CMD_PTP_LSB = 0;
    localparam int CMD_PTP_MSB = 1;
    localparam int CMD_DLY_LSB = 2;
    localparam int CMD_DLY_MSB = 3;
    localparam int CMD_SEQ_LSB = 4;
    localparam int CMD_SEQ_MSB = 5;
    localparam int CMD_DMAC = 6;
    localparam int CMD_SMAC = 7;

    localparam int MODE_SWAP = 3;
    localparam int MODE_SUB_HI = 2;
    localparam logic [3:0] MODE_NONE = 4'h0;
    localparam logic [3:0] MODE_REPL_DMAC = 4'h8;
    localparam logic [3:0] MODE_REPL_SMAC = 4'h9;
    localparam int MAC_W = 48;

    typedef enum logic [1:0] {PTP_NONE, PTP_ONE_STEP, PTP_TWO_STEP,
        PTP_TOD} ptp_op_e;
    typedef enum logic [1:0] {DLY_NONE, DLY_EGRESS, DLY_INGR1,
        DLY_INGR2} dly_sel_e;
    typedef enum logic [1:0] {SEQ_NONE, SEQ_FILL, SEQ_DREQ_RCPT,
        SEQ_DREQ_KEEP} seq_cmd_e;
    typedef enum logic {STG_EMPTY = 1'b0, STG_FULL = 1'b1} stg_e;

    typedef struct packed {
        logic [7:0] cmd;
        ptp_op_e ptp;
        logic [31:0] delay;
        logic seq_ins;
        logic [15:0] seq_num;
        logic dreq;
        logic rcpt_ts;
        logic [MAC_W-1:0] dmac;
        logic [MAC_W-1:0] smac;
        logic [7:0] ttl;
        logic [15:0] ip_csum;
        logic [15:0] sport;
        logic [15:0] dport;
        logic [15:0] l4_csum;
        logic cl_valid;
        logic [15:0] classify_result_field;
        logic [11:0] cnt_idx;
        logic log_valid;
        logic [3:0] log_int;
    } res_s;

endpackage

// ==== rw_fifo.sv ====
// Result FIFO, registered head
`timescale 1ns/1ps
module rw_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [W-1:0] od;
    } fst_s;

    fst_s q;
    fst_s d;
    logic wr;
    logic ld;
    logic full;

    always_comb
    begin
        d = q;
        // Head word counts, so DEPTH words in all
        full = (q.cnt + (AW+1)'(q.ov)) == (AW+1)'(DEPTH);
        wr = in_valid_i && !full;
        // Refill head when empty or taken
        ld = (q.cnt != '0) && (!q.ov || out_ready_i);
        if (wr)
        begin
            d.mem[q.wp] = in_data_i;
            d.wp = AW'(q.wp + 1'b1);
        end
        if (ld)
        begin
            d.od = q.mem[q.rp];
            d.ov = 1'b1;
            d.rp = AW'(q.rp + 1'b1);
        end
        else if (out_ready_i)
        begin
            d.ov = 1'b0;
        end
        d.cnt = (AW+1)'(q.cnt + (AW+1)'(wr) - (AW+1)'(ld));
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign in_ready_o = !full;
    assign out_valid_o = q.ov;
    assign out_data_o = q.od;
    assign level_o = q.cnt;
endmodule

// ==== rw_sink.sv ====
// Frame rewriter model
`timescale 1ns/1ps
module rw_sink #(
    parameter int W = 8
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic stall_i,
    input wire logic slow_i,
    input wire logic valid_i,
    output logic ready_o,
    input wire logic [W-1:0] word_i,
    output logic [W-1:0] last_o,
    output logic [31:0] count_o
);
    logic phase_q;
    // Slow: every other cycle
    assign ready_o = !stall_i && (!slow_i || phase_q);
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            phase_q <= 1'b0;
            last_o <= '0;
            count_o <= '0;
        end
        else
        begin
            phase_q <= !phase_q;
            if (valid_i && ready_o)
            begin
                last_o <= word_i;
                count_o <= count_o + 32'h1;
            end
        end
    end
endmodule
